// file: logic/light_flags_pkg.sv
// Constants, carrier structs and state record for the light sensor flag block
package light_flags_pkg;

    // Register offsets
    localparam logic [7:0] STATUS_FLAGS_OFS   = 8'h0c;
    localparam logic [7:0] PART_IDENT_OFS     = 8'h11;
    // Status field positions
    localparam int         OVERFLOW_BIT       = 3;
    localparam int         READY_BIT          = 2;
    localparam int         UPPER_BIT          = 1;
    localparam int         LOWER_BIT          = 0;
    localparam logic [3:0] STATUS_RESET       = 4'h0;
    // Identification field positions
    localparam int         CODE_LOW_POS       = 12;
    // Interrupt source encodings
    localparam logic [1:0] INT_SRC_ALERT      = 2'h0;
    localparam logic [1:0] INT_SRC_EACH       = 2'h1;
    localparam logic [1:0] INT_SRC_FOURTH     = 2'h3;
    // Serial framing
    localparam logic [3:0] BITS_PER_BYTE      = 4'h8;
    // Interrupt pulse timing
    localparam int         CLK_PERIOD_NS      = 20;
    localparam int         INT_PULSE_NS       = 1000;
    localparam logic [7:0] INT_PULSE_CYCLES   =
        8'((INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // One conversion outcome from the engine
    typedef struct packed {
        logic        done;       // One-cycle end of conversion
        logic        overflow;   // Conversion overflowed its range
        logic [3:0]  exp;        // Result exponent
        logic [19:0] mant;       // Result mantissa
    } conv_result_t;

    // Threshold limits
    typedef struct packed {
        logic [3:0]  upper_limit_exp;
        logic [19:0] upper_mant;
        logic [3:0]  lower_limit_exp;
        logic [19:0] lower_mant;
    } limits_t;

    // Configuration held elsewhere in the device
    typedef struct packed {
        logic [1:0] fault_count;  // 1,2,4,8 consecutive faults
        logic [1:0] int_source;   // Interrupt source select
        logic       int_out_dir;  // 1: pin is output, 0: input
        logic       int_active_hi;// Pin polarity
        logic       one_shot;     // Device in one-shot mode
    } config_t;

    // Serial target states
    typedef enum logic [3:0] {
        SER_IDLE      = 4'b0000,
        SER_ADDR      = 4'b0001,
        SER_ADDR_ACK  = 4'b0010,
        SER_PTR       = 4'b0011,
        SER_PTR_ACK   = 4'b0100,
        SER_WDATA     = 4'b0101,
        SER_WDATA_ACK = 4'b0110,
        SER_RDATA     = 4'b0111,
        SER_RDATA_ACK = 4'b1000
    } ser_state_t;

    // Whole state of the block
    typedef struct packed {
        logic [1:0]  scl_sync;    // Clock pin synchroniser
        logic [1:0]  sda_sync;    // Data pin synchroniser
        logic [1:0]  int_sync;    // Interrupt pin synchroniser
        logic        scl_prev;    // Last settled clock level
        logic        sda_prev;    // Last settled data level
        logic        int_prev;    // Last settled interrupt level
        ser_state_t  ser;         // Serial target state
        logic [3:0]  bit_cnt;     // Bits within a byte
        logic        byte_idx;    // High or low byte of a word
        logic        rw;          // Read transfer
        logic [7:0]  shift_in;    // Incoming byte
        logic [7:0]  pointer;     // Register pointer
        logic [7:0]  wr_high;     // Held high byte of a write
        logic [15:0] rd_word;     // Outgoing word
        logic        sda_low;     // Pull data line low
        logic [3:0]  flags;       // Status flag bits
        logic [3:0]  above_cnt;   // Consecutive high results
        logic [3:0]  below_cnt;   // Consecutive low results
        logic [1:0]  conv_cnt;    // Conversions toward fourth
        logic [7:0]  pulse_cnt;   // Interrupt pulse timer
        logic        int_low;     // Pull interrupt pin low
        logic        trigger;     // Measurement trigger pulse
    } state_t;

endpackage

// file: logic/light_flags.sv
// Status flags, identification and serial target of the light sensor
`timescale 1ns/1ps
module light_flags
#(
    parameter logic [6:0]  TARGET_ADDR    = 7'h44,  // Serial address
    parameter logic [1:0]  PART_CODE_LOW  = 2'h0,   // Arbitrary value
    parameter logic [11:0] PART_CODE_HIGH = 12'h5a3 // Arbitrary value
)
(
    input  wire logic                         clock,
    input  wire logic                         nrst,
    input  wire light_flags_pkg::conv_result_t conv,
    input  wire light_flags_pkg::limits_t     limits,
    input  wire light_flags_pkg::config_t     cfg,
    input  wire logic                         scl_i,
    output      logic                         scl_o,
    output      logic                         scl_oe,
    input  wire logic                         sda_i,
    output      logic                         sda_o,
    output      logic                         sda_oe,
    input  wire logic                         int_i,
    output      logic                         int_o,
    output      logic                         int_oe,
    output      logic                         measure_trigger,
    output      logic [3:0]                   status_flags
);
    import light_flags_pkg::*;

    state_t st;       // Present state
    state_t next_st;  // Next state

    // Needed consecutive faults for a fault count setting
    function automatic logic [3:0] need_faults(input logic [1:0] fc);
        need_faults = 4'h1 << fc;
    endfunction

    // Register read decode; unmapped offsets read zero
    function automatic logic [15:0] reg_read(input logic [7:0] ofs,
                                             input logic [3:0] fl);
        if (ofs == STATUS_FLAGS_OFS)
            reg_read = {12'h000, fl};
        else if (ofs == PART_IDENT_OFS)
            reg_read = {2'h0, PART_CODE_LOW,
                        PART_CODE_HIGH};
        else
            reg_read = 16'h0000;
    endfunction

    // Settled pin levels and their edges
    logic scl_now;
    logic sda_now;
    logic int_now;
    logic scl_rise;
    logic scl_fall;
    logic start_seen;
    logic stop_seen;
    logic is_above;      // Result above upper limit
    logic is_below;      // Result below lower limit
    logic ready_clear;   // Host access clears completion
    logic int_active;    // Interrupt condition, before polarity
    logic pin_level;     // Wanted interrupt pin level

    assign scl_now    = st.scl_sync[1];
    assign sda_now    = st.sda_sync[1];
    assign int_now    = st.int_sync[1];
    assign scl_rise   = scl_now & ~st.scl_prev;
    assign scl_fall   = ~scl_now & st.scl_prev;
    // Data moving while the clock is high frames a transfer
    assign start_seen = scl_now & st.scl_prev & st.sda_prev & ~sda_now;
    assign stop_seen  = scl_now & st.scl_prev & ~st.sda_prev & sda_now;

    assign is_above = {conv.exp, conv.mant} >
                      {limits.upper_limit_exp, limits.upper_mant};
    assign is_below = {conv.exp, conv.mant} <
                      {limits.lower_limit_exp, limits.lower_mant};

    // Next state of the whole block
    always_comb
    begin
        next_st     = st;
        ready_clear = 1'b0;
        int_active  = 1'b0;
        pin_level   = 1'b1;
        // Synchronisers: first stage feeds only the second
        next_st.scl_sync = {st.scl_sync[0], scl_i};
        next_st.sda_sync = {st.sda_sync[0], sda_i};
        next_st.int_sync = {st.int_sync[0], int_i};
        next_st.scl_prev = scl_now;
        next_st.sda_prev = sda_now;
        next_st.int_prev = int_now;

        // Serial target
        if (start_seen)
        begin
            // Start or repeated start
            next_st.ser     = SER_ADDR;
            next_st.bit_cnt = 4'h0;
        end
        else if (stop_seen)
        begin
            next_st.ser = SER_IDLE;
        end
        else if (scl_rise)
        begin
            // Host data is sampled on the rising clock
            case (st.ser)
                SER_ADDR, SER_PTR, SER_WDATA:
                begin
                    next_st.shift_in = {st.shift_in[6:0], sda_now};
                    next_st.bit_cnt  = st.bit_cnt + 4'h1;
                end
                SER_RDATA_ACK:
                begin
                    // Not acknowledged: host ends the read
                    if (sda_now)
                        next_st.ser = SER_IDLE;
                end
                default:
                begin
                    next_st.ser = st.ser;
                end
            endcase
        end
        else if (scl_fall)
        begin
            // Our data changes only while the clock is low
            case (st.ser)
                SER_ADDR:
                begin
                    if (st.bit_cnt == BITS_PER_BYTE)
                    begin
                        if (st.shift_in[7:1] == TARGET_ADDR)
                        begin
                            next_st.ser = SER_ADDR_ACK;
                            next_st.rw  = st.shift_in[0];
                        end
                        else
                        begin
                            // Other target addressed
                            next_st.ser = SER_IDLE;
                        end
                    end
                end
                SER_ADDR_ACK:
                begin
                    next_st.bit_cnt  = 4'h0;
                    next_st.byte_idx = 1'b0;
                    if (st.rw)
                    begin
                        next_st.ser     = SER_RDATA;
                        next_st.rd_word = reg_read(st.pointer, st.flags);
                        if (st.pointer == STATUS_FLAGS_OFS)
                            ready_clear = 1'b1;
                    end
                    else
                    begin
                        next_st.ser = SER_PTR;
                    end
                end
                SER_PTR:
                begin
                    if (st.bit_cnt == BITS_PER_BYTE)
                    begin
                        next_st.ser     = SER_PTR_ACK;
                        next_st.pointer = st.shift_in;
                    end
                end
                SER_PTR_ACK:
                begin
                    next_st.ser      = SER_WDATA;
                    next_st.bit_cnt  = 4'h0;
                    next_st.byte_idx = 1'b0;
                end
                SER_WDATA:
                begin
                    if (st.bit_cnt == BITS_PER_BYTE)
                        next_st.ser = SER_WDATA_ACK;
                end
                SER_WDATA_ACK:
                begin
                    next_st.ser      = SER_WDATA;
                    next_st.bit_cnt  = 4'h0;
                    next_st.byte_idx = ~st.byte_idx;
                    if (!st.byte_idx)
                    begin
                        next_st.wr_high = st.shift_in;
                    end
                    else if (st.pointer == STATUS_FLAGS_OFS &&
                             {st.wr_high, st.shift_in} != 16'h0000)
                    begin
                        // Written data is dropped; a nonzero write only clears the ready flag
                        ready_clear = 1'b1;
                    end
                end
                SER_RDATA:
                begin
                    next_st.rd_word = {st.rd_word[14:0], 1'b0};
                    if (st.bit_cnt == BITS_PER_BYTE - 4'h1)
                        next_st.ser = SER_RDATA_ACK;
                    else
                        next_st.bit_cnt = st.bit_cnt + 4'h1;
                end
                SER_RDATA_ACK:
                begin
                    // Acknowledged: send the next byte
                    next_st.ser      = SER_RDATA;
                    next_st.bit_cnt  = 4'h0;
                    next_st.byte_idx = ~st.byte_idx;
                    if (st.byte_idx)
                    begin
                        // Word done; a further read repeats the register
                        next_st.rd_word = reg_read(st.pointer, st.flags);
                        if (st.pointer == STATUS_FLAGS_OFS)
                            ready_clear = 1'b1;
                    end
                end
                default:
                begin
                    next_st.ser = SER_IDLE;
                end
            endcase
        end

        // Data line: pull low for acks and zero bits, else release
        case (next_st.ser)
            SER_ADDR_ACK, SER_PTR_ACK, SER_WDATA_ACK:
                next_st.sda_low = 1'b1;
            SER_RDATA:
                next_st.sda_low = ~next_st.rd_word[15];
            default:
                next_st.sda_low = 1'b0;
        endcase

        // Conversion outcomes update the flags
        if (conv.done)
        begin
            next_st.flags[OVERFLOW_BIT] = conv.overflow;
            // Consecutive count saturates at 15, above the largest need of 8
            if (is_above)
            begin
                if (st.above_cnt != 4'hf)
                    next_st.above_cnt = st.above_cnt + 4'h1;
            end
            else
            begin
                next_st.above_cnt = 4'h0;
            end
            if (is_below)
            begin
                if (st.below_cnt != 4'hf)
                    next_st.below_cnt = st.below_cnt + 4'h1;
            end
            else
            begin
                next_st.below_cnt = 4'h0;
            end
            next_st.flags[UPPER_BIT] =
                next_st.above_cnt >= need_faults(cfg.fault_count);
            next_st.flags[LOWER_BIT] =
                next_st.below_cnt >= need_faults(cfg.fault_count);
            next_st.conv_cnt = st.conv_cnt + 2'h1;
        end
        // Completion: an end of conversion wins over a clear
        next_st.flags[READY_BIT] =
            (st.flags[READY_BIT] & ~ready_clear) | conv.done;

        // Interrupt pulse timer for per-conversion sources
        if (conv.done &&
            (cfg.int_source == INT_SRC_EACH ||
             (cfg.int_source == INT_SRC_FOURTH &&
              st.conv_cnt == 2'h3)))
            next_st.pulse_cnt = INT_PULSE_CYCLES;
        else if (st.pulse_cnt != 8'h00)
            next_st.pulse_cnt = st.pulse_cnt - 8'h01;

        // Interrupt condition by source; the invalid code stays quiet
        case (cfg.int_source)
            INT_SRC_ALERT:
                int_active = next_st.flags[UPPER_BIT] |
                             next_st.flags[LOWER_BIT];
            INT_SRC_EACH, INT_SRC_FOURTH:
                int_active = next_st.pulse_cnt != 8'h00;
            default:
                int_active = 1'b0;
        endcase
        pin_level       = cfg.int_active_hi ? int_active : ~int_active;
        // Open drain: only the low level is driven
        next_st.int_low = cfg.int_out_dir & ~pin_level;

        // Host edge into the active level starts a one-shot measurement
        next_st.trigger = ~cfg.int_out_dir & cfg.one_shot &
                          (cfg.int_active_hi ? (int_now & ~st.int_prev)
                                             : (~int_now & st.int_prev));
    end

    // Registered state; pins released and flags clear at reset
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            st          <= '0;
            st.scl_sync <= 2'h3;
            st.sda_sync <= 2'h3;
            st.int_sync <= 2'h3;
            st.scl_prev <= 1'b1;
            st.sda_prev <= 1'b1;
            st.int_prev <= 1'b1;
            st.ser      <= SER_IDLE;
            st.flags    <= STATUS_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Pins: outputs are always low, enables decide the wire
    assign scl_o           = 1'b0;
    assign scl_oe          = 1'b0;
    assign sda_o           = 1'b0;
    assign sda_oe          = st.sda_low;
    assign int_o           = 1'b0;
    assign int_oe          = st.int_low;
    assign measure_trigger = st.trigger;
    assign status_flags    = st.flags;

endmodule

// file: verification/light_flags_checker.sv
// Pin level checks for the light sensor flag block
`timescale 1ns/1ps
module light_flags_checker
(
    input wire logic                          clock,
    input wire logic                          nrst,
    input wire light_flags_pkg::conv_result_t conv,
    input wire light_flags_pkg::limits_t      limits,
    input wire light_flags_pkg::config_t      cfg,
    input wire logic                          scl_i,
    input wire logic                          scl_o,
    input wire logic                          scl_oe,
    input wire logic                          sda_i,
    input wire logic                          sda_o,
    input wire logic                          sda_oe,
    input wire logic                          int_i,
    input wire logic                          int_o,
    input wire logic                          int_oe,
    input wire logic                          measure_trigger,
    input wire logic [3:0]                    status_flags
);
    import light_flags_pkg::*;

    logic above;  // Result strictly over the upper limit
    logic below;  // Result strictly under the lower limit

    // Exponent and mantissa compare as one number
    assign above = {conv.exp, conv.mant} >
                   {limits.upper_limit_exp, limits.upper_mant};
    assign below = {conv.exp, conv.mant} <
                   {limits.lower_limit_exp, limits.lower_mant};

    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Pins stay open drain; flags follow a done by one register stage; triggers last one cycle
    chk_pins_open_drain: assert property (
        !scl_oe && !scl_o && !sda_o && !int_o)
        else $error("pin driven high");
    chk_ready_after_done: assert property (
        conv.done |-> ##1 status_flags[READY_BIT])
        else $error("ready not set after conversion");
    chk_overflow_copy: assert property (
        conv.done |-> ##1
        status_flags[OVERFLOW_BIT] == $past(conv.overflow))
        else $error("overflow does not follow conversion");
    chk_flags_hold: assert property (
        !conv.done && !$past(conv.done) |=>
        $stable({status_flags[3], status_flags[1:0]}))
        else $error("flag moved without conversion");
    chk_ready_cause: assert property (
        $rose(status_flags[READY_BIT]) |->
        $past(conv.done))
        else $error("ready rose without conversion");
    chk_upper_one: assert property (
        conv.done && above && cfg.fault_count == 2'h0 |->
        ##1 status_flags[UPPER_BIT])
        else $error("upper flag missing");
    chk_lower_one: assert property (
        conv.done && below && cfg.fault_count == 2'h0 |->
        ##1 status_flags[LOWER_BIT])
        else $error("lower flag missing");
    chk_upper_drop: assert property (
        conv.done && !above |-> ##1 !status_flags[UPPER_BIT])
        else $error("upper flag kept after run broke");
    chk_each_pulse: assert property (
        conv.done && cfg.int_out_dir && !cfg.int_active_hi &&
        cfg.int_source == INT_SRC_EACH |-> ##[1:2] int_oe)
        else $error("no interrupt after conversion");
    chk_input_released: assert property (
        !cfg.int_out_dir && !$past(cfg.int_out_dir) |-> !int_oe)
        else $error("input pin driven");
    chk_trigger_cause: assert property (
        measure_trigger |-> !cfg.int_out_dir && cfg.one_shot)
        else $error("trigger outside one-shot input mode");
    chk_trigger_single: assert property (
        measure_trigger |=> !measure_trigger)
        else $error("trigger longer than one cycle");
endmodule

bind light_flags light_flags_checker chk (.*);

// file: verification/serial_host_model.sv
// Host controller model that runs register transfers on the serial pins
`timescale 1ns/1ps
module serial_host_model
#(
    parameter int HALF = 6  // Clocks per half bit, above the advised 5
)
(
    input  wire logic clock,
    input  wire logic sda_line,
    output      logic scl_low,
    output      logic sda_low
);
    logic [8:0] got;  // Last nine sampled data bits, ack at bit 0

    // Lines start released so the bus idles high
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        got     = 9'h1ff;
    end

    // One half bit; all moves happen on falling edges
    task automatic hold();
        repeat (HALF) @(negedge clock);
    endtask

    // Start or repeated start: data falls while clock is high
    task automatic start();
        sda_low = 1'b0;
        hold();
        scl_low = 1'b0;
        hold();
        sda_low = 1'b1;
        hold();
        scl_low = 1'b1;
        hold();
    endtask

    // Stop: data rises while clock is high
    task automatic stop();
        sda_low = 1'b1;
        hold();
        scl_low = 1'b0;
        hold();
        sda_low = 1'b0;
        hold();
    endtask

    // Data only changes while clock is low; sampled late in high phase
    task automatic bit_io(input logic b);
        sda_low = !b;
        hold();
        scl_low = 1'b0;
        hold();
        got = {got[7:0], sda_line};
        scl_low = 1'b1;
        hold();
    endtask

    // Eight bits MSB first, then the acknowledge slot
    task automatic xfer(input logic [7:0] tx, input logic ack_in);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i]);
        bit_io(ack_in);
    endtask

    // Pointer then one word, high byte first
    task automatic wr(input logic [6:0] a, input logic [7:0] p,
                      input logic [15:0] w, output logic ok);
        logic [31:0] seq;
        seq = {a, 1'b0, p, w};
        ok = 1'b1;
        start();
        for (int k = 3; k >= 0; k--)
        begin
            xfer(seq[8*k +: 8], 1'b1);
            ok = ok && !got[0];
        end
        stop();
    endtask

    // Pointer write, repeated start, two bytes, nack on the last
    task automatic rd(input logic [6:0] a, input logic [7:0] p,
                      output logic [15:0] w, output logic ok);
        start();
        xfer({a, 1'b0}, 1'b1);
        ok = !got[0];
        xfer(p, 1'b1);
        ok = ok && !got[0];
        start();
        xfer({a, 1'b1}, 1'b1);
        ok = ok && !got[0];
        xfer(8'hff, 1'b0);
        w[15:8] = got[8:1];
        xfer(8'hff, 1'b1);
        w[7:0] = got[8:1];
        stop();
    endtask
endmodule

// file: verification/light_flags_bench.sv
// Register level regression for the light sensor flag block
`timescale 1ns/1ps
module light_flags_bench;
    import light_flags_pkg::*;

    localparam logic [6:0]  ADDR    = 7'h44;     // Serial address
    localparam logic [1:0]  ID_LOW  = 2'h2;      // Arbitrary value
    localparam logic [11:0] ID_HIGH = 12'h3c6;   // Arbitrary value
    localparam logic [23:0] HI      = 24'h900000; // Over upper limit
    localparam logic [23:0] MID     = 24'h500000; // Between limits
    localparam logic [23:0] LO      = 24'h100000; // Under lower limit
    localparam int          LIMIT   = 60000;     // Cycle ceiling

    logic         clock;
    logic         nrst;
    conv_result_t conv;
    limits_t      limits;
    config_t      cfg;
    logic         scl_low, sda_low, int_low;  // Parties pulling low
    logic         scl_line, sda_line, int_line;
    logic         scl_o, scl_oe, sda_o, sda_oe, int_o, int_oe;
    logic         measure_trigger;
    logic [3:0]   status_flags;
    logic         seen;
    int           err_total = 0;
    int           n_tests   = 0;
    int           n_done    = 0;  // Conversions since reset
    int           cycles    = 0;

    // Pull-ups win unless some party pulls low
    assign scl_line = !(scl_low || scl_oe);
    assign sda_line = !(sda_low || sda_oe);
    assign int_line = !(int_low || int_oe);

    light_flags #(.TARGET_ADDR(ADDR), .PART_CODE_LOW(ID_LOW),
                  .PART_CODE_HIGH(ID_HIGH)) DUT (
        .clock(clock), .nrst(nrst), .conv(conv), .limits(limits),
        .cfg(cfg), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .int_i(int_line), .int_o(int_o), .int_oe(int_oe),
        .measure_trigger(measure_trigger), .status_flags(status_flags));

    serial_host_model host (.clock(clock), .sda_line(sda_line),
                            .scl_low(scl_low), .sda_low(sda_low));

    // 50 MHz clock
    always #10 clock = ~clock;

    // Cuts a hang short and reports it as a mismatch
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] want,
                         input string what);
        n_tests++;
        if (got !== want)
        begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h",
                     $time, what, got, want);
        end
    endtask

    task automatic rd_check(input logic [7:0] p, input logic [15:0] want,
                            input string what);
        logic [15:0] w;
        logic        ok;
        host.rd(ADDR, p, w, ok);
        check(16'(ok), 16'h1, "read acknowledge");
        check(w, want, what);
    endtask

    task automatic wr_check(input logic [6:0] a, input logic [7:0] p,
                            input logic [15:0] w, input logic want_ok);
        logic ok;
        host.wr(a, p, w, ok);
        check(16'(ok), 16'(want_ok), "write acknowledge");
    endtask

    // One-cycle done, then two idle cycles for the flags to settle
    task automatic convert(input logic ovf, input logic [23:0] v);
        conv = {1'b1, ovf, v};
        @(negedge clock);
        conv.done = 1'b0;
        n_done++;
        repeat (2) @(negedge clock);
    endtask

    initial
    begin
        clock   = 1'b0;
        nrst    = 1'b0;
        conv    = '0;
        int_low = 1'b0;
        limits  = {4'h8, 20'h0, 4'h2, 20'h0};
        cfg     = {2'h0, INT_SRC_EACH, 1'b1, 1'b0, 1'b0};
        repeat (10) @(negedge clock);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        check(16'(status_flags), 16'h0, "flags after reset");
        rd_check(PART_IDENT_OFS, {2'h0, ID_LOW, ID_HIGH}, "ident");
        wr_check(ADDR, PART_IDENT_OFS, 16'hffff, 1'b1);
        rd_check(PART_IDENT_OFS, {2'h0, ID_LOW, ID_HIGH}, "ident");
        rd_check(8'h0d, 16'h0, "unmapped offset");
        convert(1'b1, MID);
        check(16'(int_oe), 16'h1, "sample pulse");
        rd_check(STATUS_FLAGS_OFS, 16'h000c, "done flags");
        rd_check(STATUS_FLAGS_OFS, 16'h0008, "read clears");
        check(16'(int_oe), 16'h0, "pulse ended");
        convert(1'b1, HI);
        wr_check(ADDR, STATUS_FLAGS_OFS, 16'h0000, 1'b1);
        check(16'(status_flags), 16'h000e, "zero write");
        wr_check(ADDR, STATUS_FLAGS_OFS, 16'hffff, 1'b1);
        check(16'(status_flags), 16'h000a, "nonzero write");
        wr_check(7'h45, STATUS_FLAGS_OFS, 16'h0001, 1'b0);
        // Alert mode mirrors the limit flags on the pin
        cfg.int_source = INT_SRC_ALERT;
        for (int fc = 0; fc < 4; fc++)
        begin
            cfg.fault_count = 2'(fc);
            convert(1'b0, MID);
            for (int i = 1; i <= (1 << fc); i++)
            begin
                convert(1'b0, HI);
                check(16'(status_flags[1:0]), 16'({i == (1 << fc), 1'b0}),
                      "upper run");
                check(16'(int_oe), 16'(i == (1 << fc)), "alert");
            end
            for (int i = 1; i <= (1 << fc); i++)
            begin
                convert(1'b0, LO);
                check(16'(status_flags[1:0]), 16'(i == (1 << fc)),
                      "lower run");
            end
        end
        cfg.int_source = INT_SRC_FOURTH;
        repeat (4)
        begin
            convert(1'b0, MID);
            check(16'(int_oe), 16'(n_done % 4 == 0), "fourth");
            repeat (60) @(negedge clock);
        end
        cfg.int_source = 2'h2;
        convert(1'b0, MID);
        check(16'(int_oe), 16'h0, "invalid source");
        // Host drives the input pin active, low then high
        for (int p = 0; p < 2; p++)
        begin
            cfg = {2'h0, INT_SRC_EACH, 1'b0, 1'(p), 1'b1};
            repeat (4) @(negedge clock);
            int_low = !int_low;
            seen = 1'b0;
            repeat (12)
            begin
                @(negedge clock);
                seen = seen | measure_trigger;
            end
            check(16'(seen), 16'h1, "trigger");
        end
        cfg.int_out_dir = 1'b1;
        convert(1'b0, MID);
        check(16'(int_oe), 16'h0, "high pulse");
        stop_test();
    end
endmodule
